/* File: design/sco_page_match.sv */
// Page window compare for one relocatable region.
// Assumes a 16-bit bus address and a region no larger than one 4 KB page.
`timescale 1ns/1ps
module sco_page_match #(
    parameter int SPAN = 256
) (
    input wire logic [15:0] addr,
    input wire logic [3:0] page,
    output logic hit
);
    localparam logic [12:0] SPAN_W = 13'(SPAN);

    // Upper nibble picks the page, low bits must fall inside the region
    assign hit = (addr[15:12] == page) && ({1'b0, addr[11:0]} < SPAN_W);
endmodule // sco_page_match

/* File: design/sco_pkg.sv */
// Constants shared by the system configuration options block.
// Assumes a 125 MHz pclk and one APB slave port at a 4 KB aligned base.
package sco_pkg;

    // APB register byte offsets
    localparam logic [7:0] SCO_OFS_OPTIONS = 8'h00;
    localparam logic [7:0] SCO_OFS_BASE = 8'h04;
    localparam logic [7:0] SCO_OFS_STATUS = 8'h08;

    // Field positions in the options register
    localparam int SCO_BIT_PWR = 7;
    localparam int SCO_BIT_ALT_CLOCK_SELECT = 6;
    localparam int SCO_BIT_IRQ_EDGE_ONLY = 5;
    localparam int SCO_BIT_DLY = 4;
    localparam int SCO_BIT_CME = 3;
    localparam int SCO_BIT_ZERO = 2;

    // Bits that lock after the first write following reset, then the bits that are implemented
    localparam logic [7:0] SCO_OPT_PROT_MASK = 8'h33;
    localparam logic [7:0] SCO_OPT_IMPL_MASK = 8'hfb;

    // Reset values
    localparam logic [7:0] SCO_OPT_RESET = 8'h10;
    localparam logic [3:0] SCO_RAM_PAGE_RESET = 4'h0;
    localparam logic [3:0] SCO_REG_PAGE_RESET = 4'h1;

    // Mapped sizes within a 4 KB page
    localparam int SCO_PAGE_BYTES = 4096;
    localparam int SCO_REG_BYTES = 64;
    localparam int SCO_RAM_BYTES = 256;

    // Timing
    localparam int SCO_CLK_MHZ = 125;
    localparam int SCO_STOP_LONG_CYC = 4000;
    localparam int SCO_STOP_SHORT_CYC = 4;
    localparam int SCO_ADC_SETTLE_US = 100;
    localparam int SCO_ADC_SETTLE_CYC = SCO_ADC_SETTLE_US * SCO_CLK_MHZ;

    // Stop sequencer states
    typedef enum logic [1:0] {
        SCO_RUN = 2'b00,
        SCO_STOPPED = 2'b01,
        SCO_RESUME = 2'b10
    } sco_state_t;

endpackage

/* File: design/sco_top.sv */
// System configuration options: relocation selects, options register, stop-exit sequencer.
// Assumes an APB master on pclk, cpu_addr and stop_req from logic on pclk, and
// stop_wake and rc_osc_in arriving from outside the clock domain.
`timescale 1ns/1ps
module sco_top
    import sco_pkg::*;
#(
    parameter int RAM_BYTES = SCO_RAM_BYTES,
    parameter int LONG_DELAY_CYC = SCO_STOP_LONG_CYC,
    parameter int ADC_SETTLE_CYC = SCO_ADC_SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] cpu_addr,
    output logic ram_select,
    output logic reg_select,
    input wire logic stop_req,
    input wire logic stop_wake,
    output logic cpu_run,
    input wire logic rc_osc_in,
    output logic converter_power_up,
    output logic converter_clk_en,
    output logic pump_clk_en,
    output logic alt_clock_select,
    output logic irq_edge_only,
    output logic clock_monitor_enable,
    output logic [1:0] watchdog_rate_select
);

    // Elaboration checks on parameters the counters and compare can serve
    generate
        if (RAM_BYTES < 1 || RAM_BYTES > SCO_PAGE_BYTES) begin : g_bad_ram
            $error("RAM_BYTES must fit in one 4 KB page");
        end
        if (LONG_DELAY_CYC < SCO_STOP_SHORT_CYC || LONG_DELAY_CYC > 4095) begin : g_bad_dly
            $error("LONG_DELAY_CYC must lie between the short delay and 4095");
        end
        if (ADC_SETTLE_CYC < 1 || ADC_SETTLE_CYC > 65535) begin : g_bad_settle
            $error("ADC_SETTLE_CYC must lie between 1 and 65535");
        end
    endgenerate

    localparam logic [11:0] LONG_LAST = 12'(LONG_DELAY_CYC - 1);
    localparam logic [11:0] SHORT_LAST = 12'(SCO_STOP_SHORT_CYC - 1);
    localparam logic [15:0] SETTLE_LAST = 16'(ADC_SETTLE_CYC - 1);

    // Register state
    logic [7:0] opt_r;
    logic [7:0] opt_nxt;
    logic opt_locked_r;
    logic [3:0] ram_page_r;
    logic [3:0] reg_page_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic ram_select_r;
    logic reg_select_r;

    // Stop sequencer state
    sco_state_t state_r;
    sco_state_t state_nxt;
    logic [11:0] dly_cnt_r;
    logic [11:0] dly_cnt_nxt;
    logic cpu_run_r;

    // Converter state
    logic [15:0] settle_cnt_r;
    logic adc_ready_r;
    logic conv_clk_en_r;

    // Synchronisers for pin inputs
    logic wake_meta_r;
    logic wake_sync_r;
    logic rc_meta_r;
    logic rc_sync_r;
    logic rc_prev_r;

    // APB decode
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic hit_opt;
    logic hit_base;
    logic hit_status;
    logic mapped;
    logic [31:0] rd_mux;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_r;
    assign wr_done = access_done && pwrite && !pslverr_r;
    assign hit_opt = (paddr[31:8] == 24'h000000) && (paddr[7:0] == SCO_OFS_OPTIONS);
    assign hit_base = (paddr[31:8] == 24'h000000) && (paddr[7:0] == SCO_OFS_BASE);
    assign hit_status = (paddr[31:8] == 24'h000000) && (paddr[7:0] == SCO_OFS_STATUS);
    assign mapped = hit_opt || hit_base || hit_status;

    // Read data; bit 2 is never stored, so it reads zero
    assign rd_mux = hit_opt ? {24'h000000, opt_r & SCO_OPT_IMPL_MASK} :
                    hit_base ? {24'h000000, reg_page_r, ram_page_r} :
                    hit_status ? {24'h000000, 1'b0, adc_ready_r, opt_locked_r, cpu_run_r,
                                  2'b00, state_r} :
                    32'h00000000;

    // No wait states: answer is prepared during setup and presented in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= setup_phase;
            pslverr_r <= setup_phase && !mapped;
            if (setup_phase) begin
                prdata_r <= (pwrite || !mapped) ? 32'h00000000 : rd_mux;
            end
        end
    end

    // Protected bits keep their value once the first write has landed
    assign opt_nxt = opt_locked_r ?
        ((opt_r & SCO_OPT_PROT_MASK) | (pwdata[7:0] & ~SCO_OPT_PROT_MASK & SCO_OPT_IMPL_MASK)) :
        (pwdata[7:0] & SCO_OPT_IMPL_MASK);

    // Options register and its write-once lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_r <= SCO_OPT_RESET;
            opt_locked_r <= 1'b0;
        end else if (wr_done && hit_opt) begin
            opt_r <= opt_nxt;
            opt_locked_r <= 1'b1;
        end
    end

    // Page selectors for RAM and the register block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_page_r <= SCO_RAM_PAGE_RESET;
            reg_page_r <= SCO_REG_PAGE_RESET;
        end else if (wr_done && hit_base) begin
            ram_page_r <= pwdata[3:0];
            reg_page_r <= pwdata[7:4];
        end
    end

    // Address compare against both pages
    logic ram_hit;
    logic reg_hit;

    sco_page_match #(
        .SPAN(RAM_BYTES)
    ) u_ram_match (
        .addr(cpu_addr),
        .page(ram_page_r),
        .hit(ram_hit)
    );

    sco_page_match #(
        .SPAN(SCO_REG_BYTES)
    ) u_reg_match (
        .addr(cpu_addr),
        .page(reg_page_r),
        .hit(reg_hit)
    );

    // Selects are registered so a selector change applies from the next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_select_r <= 1'b0;
            reg_select_r <= 1'b0;
        end else begin
            ram_select_r <= ram_hit;
            reg_select_r <= reg_hit;
        end
    end

    // Two-flop synchronisers; wake uses the second stage, the RC edge detect the second and a third
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_meta_r <= 1'b0;
            wake_sync_r <= 1'b0;
            rc_meta_r <= 1'b0;
            rc_sync_r <= 1'b0;
            rc_prev_r <= 1'b0;
        end else begin
            wake_meta_r <= stop_wake;
            wake_sync_r <= wake_meta_r;
            rc_meta_r <= rc_osc_in;
            rc_sync_r <= rc_meta_r;
            rc_prev_r <= rc_sync_r;
        end
    end

    // Converter and charge pump share one enable, low while powered down; when powered: every cycle on the bus clock,
    // one pulse per rising RC edge otherwise. The RC rate must stay well below pclk/2.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clk_en_r <= 1'b0;
        end else if (!opt_r[SCO_BIT_PWR]) begin
            conv_clk_en_r <= 1'b0;
        end else if (opt_r[SCO_BIT_ALT_CLOCK_SELECT]) begin
            conv_clk_en_r <= rc_sync_r && !rc_prev_r;
        end else begin
            conv_clk_en_r <= 1'b1;
        end
    end

    // Bias settle timer, read back as a status bit for software that waits on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt_r <= 16'h0000;
            adc_ready_r <= 1'b0;
        end else if (!opt_r[SCO_BIT_PWR]) begin
            settle_cnt_r <= 16'h0000;
            adc_ready_r <= 1'b0;
        end else if (settle_cnt_r == SETTLE_LAST) begin
            adc_ready_r <= 1'b1;
        end else begin
            settle_cnt_r <= settle_cnt_r + 16'h0001;
        end
    end

    // Stop sequencer: halts on request, resumes after wake plus the chosen delay
    always_comb begin
        state_nxt = state_r;
        dly_cnt_nxt = dly_cnt_r;
        case (state_r)
            SCO_RUN: begin
                if (stop_req) begin
                    state_nxt = SCO_STOPPED;
                end
            end
            SCO_STOPPED: begin
                if (wake_sync_r) begin
                    state_nxt = SCO_RESUME;
                    dly_cnt_nxt = opt_r[SCO_BIT_DLY] ? LONG_LAST : SHORT_LAST;
                end
            end
            SCO_RESUME: begin
                if (dly_cnt_r == 12'h000) begin
                    state_nxt = SCO_RUN;
                end else begin
                    dly_cnt_nxt = dly_cnt_r - 12'h001;
                end
            end
            default: begin
                state_nxt = SCO_RUN;
                dly_cnt_nxt = 12'h000;
            end
        endcase
    end

    // Sequencer state and the run output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SCO_RUN;
            dly_cnt_r <= 12'h000;
            cpu_run_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            dly_cnt_r <= dly_cnt_nxt;
            cpu_run_r <= (state_nxt == SCO_RUN);
        end
    end

    // Outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign ram_select = ram_select_r;
    assign reg_select = reg_select_r;
    assign cpu_run = cpu_run_r;
    assign converter_power_up = opt_r[SCO_BIT_PWR];
    assign converter_clk_en = conv_clk_en_r;
    assign pump_clk_en = conv_clk_en_r;
    assign alt_clock_select = opt_r[SCO_BIT_ALT_CLOCK_SELECT];
    assign irq_edge_only = opt_r[SCO_BIT_IRQ_EDGE_ONLY];
    assign clock_monitor_enable = opt_r[SCO_BIT_CME];
    assign watchdog_rate_select = opt_r[1:0];

endmodule // sco_top

/* File: dv/sco_checker.sv */
// Port checker for sco_top.
// Assumes one pclk domain and is bound into every sco_top.
`timescale 1ns/1ps
module sco_checker
    import sco_pkg::*;
#(
    parameter int LONG_DELAY_CYC = SCO_STOP_LONG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] cpu_addr,
    input wire logic ram_select,
    input wire logic reg_select,
    input wire logic stop_req,
    input wire logic stop_wake,
    input wire logic cpu_run,
    input wire logic converter_power_up,
    input wire logic converter_clk_en,
    input wire logic pump_clk_en,
    input wire logic alt_clock_select,
    input wire logic irq_edge_only,
    input wire logic [1:0] watchdog_rate_select
);
    localparam int WAKE_MAX = LONG_DELAY_CYC + 8;
    logic locked_r;
    logic [3:0] ram_pg_r;
    logic [3:0] reg_pg_r;
    wire wr_done = psel && penable && pready && pwrite;
    wire ram_hit = cpu_addr[15:12] == ram_pg_r && cpu_addr[11:8] == 4'h0;
    wire reg_hit = cpu_addr[15:12] == reg_pg_r && cpu_addr[11:6] == 6'h00;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Mirror of lock and pages, taken at the same edge as the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_r <= 1'b0;
            ram_pg_r <= SCO_RAM_PAGE_RESET;
            reg_pg_r <= SCO_REG_PAGE_RESET;
        end else if (wr_done && paddr == 32'h0) begin
            locked_r <= 1'b1;
        end else if (wr_done && paddr == 32'h4) begin
            ram_pg_r <= pwdata[3:0];
            reg_pg_r <= pwdata[7:4];
        end
    end
    // Past reset guard: selects still hold their reset value at the first edge
    property p_ram;
        $past(presetn) |-> ram_select == $past(ram_hit);
    endproperty
    a_ram: assert property (p_ram) else $error("ram select wrong");
    property p_reg;
        $past(presetn) |-> reg_select == $past(reg_hit);
    endproperty
    a_reg: assert property (p_reg) else $error("reg select wrong");
    property p_lock;
        locked_r |=> $stable({irq_edge_only, watchdog_rate_select});
    endproperty
    a_lock: assert property (p_lock) else $error("locked bit moved");
    property p_pwr;
        !converter_power_up && !$past(converter_power_up) |-> !converter_clk_en;
    endproperty
    a_pwr: assert property (p_pwr) else $error("clock while off");
    property p_alt_clock_select;
        converter_power_up && !alt_clock_select && $past(converter_power_up)
            && !$past(alt_clock_select) |-> converter_clk_en;
    endproperty
    a_alt_clock_select: assert property (p_alt_clock_select) else $error("bus clock gap");
    property p_pump;
        converter_clk_en == pump_clk_en;
    endproperty
    a_pump: assert property (p_pump) else $error("pump clock differs");
    property p_short;
        $rose(stop_wake) && !cpu_run |-> !cpu_run [*5];
    endproperty
    a_short: assert property (p_short) else $error("resume too soon");
    property p_long;
        $rose(stop_wake) && !cpu_run |-> ##[1:WAKE_MAX] cpu_run;
    endproperty
    a_long: assert property (p_long) else $error("resume too late");
    property p_stop;
        cpu_run && stop_req |=> !cpu_run;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_bit2;
        pready && !pwrite && paddr == 32'h0 |-> !prdata[SCO_BIT_ZERO];
    endproperty
    a_bit2: assert property (p_bit2) else $error("bit 2 set");
    c_err: cover property (pready && pslverr);
    c_run: cover property ($rose(cpu_run));
    c_ram: cover property (ram_select);
endmodule // sco_checker

bind sco_top sco_checker #(.LONG_DELAY_CYC(LONG_DELAY_CYC)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_addr, .ram_select,
    .reg_select, .stop_req, .stop_wake, .cpu_run, .converter_power_up, .converter_clk_en,
    .pump_clk_en, .alt_clock_select, .irq_edge_only, .watchdog_rate_select);

/* File: dv/system_config_options_test.sv */
// Self-checking bench for sco_top over APB.
// Assumes the checker is bound in; the long stop delay shortened by parameter.
`timescale 1ns/1ps
module system_config_options_test import sco_pkg::*;;
    localparam int LONG = 40;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] cpu_addr = 16'hffff;
    logic stop_req = 1'b0;
    logic stop_wake = 1'b0;
    logic [2:0] rc_div = 3'h0;
    logic [31:0] prdata;
    logic [1:0] watchdog_rate_select;
    logic pready, pslverr, ram_select, reg_select, cpu_run, converter_power_up;
    logic converter_clk_en, pump_clk_en, alt_clock_select, irq_edge_only, clock_monitor_enable;
    logic [31:0] rd;
    logic er;
    int n;
    int err_total = 0;
    int check_count = 0;
    logic [15:0] ta [5] = '{16'ha0ff, 16'ha100, 16'h203f, 16'h2040, 16'h1010};
    logic [1:0] te [5] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0};

    sco_top #(.LONG_DELAY_CYC(LONG), .ADC_SETTLE_CYC(10)) DUT (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_addr,
        .ram_select, .reg_select, .stop_req, .stop_wake, .cpu_run, .rc_osc_in(rc_div[2]),
        .converter_power_up, .converter_clk_en, .pump_clk_en, .alt_clock_select,
        .irq_edge_only, .clock_monitor_enable, .watchdog_rate_select);

    // Clock, and a slow stand-in for the RC oscillator
    always #4 pclk = ~pclk;
    always @(posedge pclk) rc_div <= rc_div + 3'h1;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; data and error taken at the pready edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k == 16) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in the same step
        @(posedge pclk);
    endtask

    task automatic rst();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // Stop, wake, and count edges until processing resumes
    task automatic stop_cycle(input int lo, input int hi);
        stop_req <= 1'b1;
        @(posedge pclk);
        stop_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(cpu_run, 1'b0);
        stop_wake <= 1'b1;
        n = 0;
        while (cpu_run !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        stop_wake <= 1'b0;
        chk(n >= lo && n <= hi, 1'b1);
    endtask

    task automatic final_report();
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        rst();
        apb(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, 32'h4, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, 32'h0, 32'hef);
        apb(1'b0, 32'h0, 32'h0);
        chk(rd, 32'heb);
        chk({irq_edge_only, watchdog_rate_select}, 32'h7);
        chk({alt_clock_select, clock_monitor_enable}, 32'h3);
        apb(1'b1, 32'h0, 32'h0);
        apb(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h23);
        chk(converter_power_up, 1'b0);
        stop_cycle(4, 10);
        apb(1'b1, 32'h0, 32'h80);
        repeat (20) @(posedge pclk);
        chk(converter_clk_en, 1'b1);
        apb(1'b0, 32'h8, 32'h0);
        chk(rd, 32'h70);
        apb(1'b1, 32'h0, 32'hc0);
        n = 0;
        repeat (32) begin
            @(posedge pclk);
            n += int'(converter_clk_en);
        end
        chk(n, 32'h4);
        apb(1'b0, 32'hc, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 32'h4, 32'h2a);
        apb(1'b0, 32'h4, 32'h0);
        chk(rd, 32'h2a);
        foreach (ta[i]) begin
            cpu_addr <= ta[i];
            repeat (2) @(posedge pclk);
            chk({ram_select, reg_select}, te[i]);
        end
        rst();
        apb(1'b1, 32'h0, 32'h90);
        apb(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h90);
        stop_cycle(LONG, LONG + 10);
        final_report();
    end

    // Watchdog: the full sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        final_report();
    end
endmodule // system_config_options_test
